// ---- vcpu_prio_pkg.sv ----
// Purpose: shared constants for the virtual cpu interface priority registers
// Assumes: coprocessor access fields arrive as decoded opcode fields
// Notes:   encodings are four-bit register fields and three-bit opcodes
package vcpu_prio_pkg;

  localparam int          PRIO_W         = 8;
  localparam int          DATA_W         = 32;
  localparam logic [3:0]  PMASK_CRN      = 4'h4;
  localparam logic [3:0]  PMASK_CRM      = 4'h6;
  localparam logic [2:0]  PMASK_OPC2     = 3'h0;
  localparam logic [3:0]  RUNPRI_CRN     = 4'hC;
  localparam logic [3:0]  RUNPRI_CRM     = 4'hB;
  localparam logic [2:0]  RUNPRI_OPC2    = 3'h3;
  localparam logic [3:0]  GRP1EN_CRN     = 4'hC;
  localparam logic [3:0]  GRP1EN_CRM     = 4'hC;
  localparam logic [2:0]  GRP1EN_OPC2    = 3'h7;
  localparam logic [2:0]  OPC1_GUEST     = 3'h0;
  localparam logic [3:0]  COPROC_SYS     = 4'hF;
  localparam logic [7:0]  PMASK_RESET    = 8'h00;
  localparam logic [7:0]  IDLE_PRIORITY  = 8'hFF;
  localparam logic        GRP1EN_RESET   = 1'b0;

  // outcome of one register access
  typedef enum logic [2:0] {
    RESP_OK_VIRT  = 3'b000,
    RESP_OK_PHYS  = 3'b001,
    RESP_UNDEF    = 3'b010,
    RESP_TRAP_GST = 3'b011,
    RESP_TRAP_HYP = 3'b100,
    RESP_NONE     = 3'b101
  } resp_type;

  // which register an access names
  typedef enum logic [1:0] {
    SEL_NONE   = 2'b00,
    SEL_PMASK  = 2'b01,
    SEL_RUNPRI = 2'b10,
    SEL_GRP1EN = 2'b11
  } sel_type;

  // keep only the implemented high priority bits
  function automatic logic [7:0] prioKeep(input logic [7:0] v, input int bits);
    logic [7:0] m;
    m = 8'hFF << (PRIO_W - bits);
    return v & m;
  endfunction

endpackage

// ---- vcpu_route_check.sv ----
// Purpose: routing and trap decision for guest-level accesses
// Assumes: all control inputs are stable core-clock signals
// Notes:   purely combinational; priority order is undefined, trap guest, trap hyp
`timescale 1ns/1ps
module vcpu_route_check
  import vcpu_prio_pkg::*;
(
  input  wire sel_type  sel,
  input  wire logic     nonsecureSelect,
  input  wire logic     guestLevel,
  input  wire logic     fastIrqRouteOverride,
  input  wire logic     normalIrqRouteOverride,
  input  wire logic     sysregIfaceEnable32,
  input  wire logic     sysregIfaceEnable64,
  input  wire logic     hypImplemented,
  input  wire logic     hypGroupTrap,
  input  wire logic     trapAllGroup1,
  input  wire logic     trapCommon,
  output resp_type      resp
);

  logic nsGuest;
  assign nsGuest = guestLevel && nonsecureSelect;

  // trap and routing decision
  always_comb
  begin
    resp = RESP_OK_VIRT;
    if (sel == SEL_NONE)
      resp = RESP_NONE;
    else if (nsGuest && !sysregIfaceEnable32)
      resp = RESP_UNDEF;
    else if (nsGuest && !sysregIfaceEnable64)
      resp = RESP_TRAP_GST;
    else if (nsGuest && hypImplemented && hypGroupTrap && sel != SEL_PMASK)
      resp = RESP_TRAP_HYP;
    else if (nsGuest && sel == SEL_GRP1EN && trapAllGroup1)
      resp = RESP_TRAP_HYP;
    else if (nsGuest && sel != SEL_GRP1EN && trapCommon)
      resp = RESP_TRAP_HYP;
    else if (nsGuest && sel == SEL_GRP1EN && !normalIrqRouteOverride)
      resp = RESP_OK_PHYS;
    else if (nsGuest && sel != SEL_GRP1EN && !fastIrqRouteOverride
             && !normalIrqRouteOverride)
      resp = RESP_OK_PHYS;
  end

endmodule

// ---- vcpu_prio_regs.sv ----
// Purpose: virtual priority mask, running priority and group 1 enable logic
// Assumes: one access request per cycle, answered on the next cycle
// Notes:   physical registers live outside; physical accesses are forwarded
`timescale 1ns/1ps

module vcpu_prio_regs
  import vcpu_prio_pkg::*;
#(
  parameter int PRIO_BITS = PRIO_W
)
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              accValid,
  input  wire logic              accWrite,
  input  wire logic [3:0]        accCoproc,
  input  wire logic [2:0]        accOpc1,
  input  wire logic [3:0]        accCrn,
  input  wire logic [3:0]        accCrm,
  input  wire logic [2:0]        accOpc2,
  input  wire logic [DATA_W-1:0] accWdata,
  input  wire logic              nonsecureSelect,
  input  wire logic              guestLevel,
  input  wire logic              fastIrqRouteOverride,
  input  wire logic              normalIrqRouteOverride,
  input  wire logic              sysregIfaceEnable32,
  input  wire logic              sysregIfaceEnable64,
  input  wire logic              hypImplemented,
  input  wire logic              hypGroupTrap,
  input  wire logic              trapAllGroup1,
  input  wire logic              trapCommon,
  input  wire logic              activeValid,
  input  wire logic [7:0]        activePriority,
  input  wire logic              pendValid,
  input  wire logic [7:0]        pendPriority,
  input  wire logic [DATA_W-1:0] physRdata,
  output logic                   respValid,
  output resp_type               respCode,
  output logic [DATA_W-1:0]      respRdata,
  output logic                   physReq,
  output logic                   physWrite,
  output sel_type                physSel,
  output logic [DATA_W-1:0]      physWdata,
  output logic                   virtIrq,
  output logic                   group1Enable
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]        pmask;
    logic              grp1En;
    logic              respValid;
    resp_type          respCode;
    logic [DATA_W-1:0] respRdata;
    logic              physReq;
    logic              physWrite;
    sel_type           physSel;
    logic [DATA_W-1:0] physWdata;
    logic              virtIrq;
  } state_type;

  state_type stateQ;
  state_type stateD;
  sel_type   sel;
  resp_type  route;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  function automatic logic encMatch(input logic [3:0] crn, input logic [3:0] crm,
                                    input logic [2:0] opc2);
    return accCoproc == COPROC_SYS && accOpc1 == OPC1_GUEST && accCrn == crn
           && accCrm == crm && accOpc2 == opc2;
  endfunction

  // select the named register; running priority writes are not mapped
  always_comb
  begin
    sel = SEL_NONE;
    if (accValid)
    begin
      if (encMatch(PMASK_CRN, PMASK_CRM, PMASK_OPC2))
        sel = SEL_PMASK;
      else if (encMatch(RUNPRI_CRN, RUNPRI_CRM, RUNPRI_OPC2) && !accWrite)
        sel = SEL_RUNPRI;
      else if (encMatch(GRP1EN_CRN, GRP1EN_CRM, GRP1EN_OPC2))
        sel = SEL_GRP1EN;
    end
  end

  vcpu_route_check u_route (
    .sel                    (sel),
    .nonsecureSelect        (nonsecureSelect),
    .guestLevel             (guestLevel),
    .fastIrqRouteOverride   (fastIrqRouteOverride),
    .normalIrqRouteOverride (normalIrqRouteOverride),
    .sysregIfaceEnable32    (sysregIfaceEnable32),
    .sysregIfaceEnable64    (sysregIfaceEnable64),
    .hypImplemented         (hypImplemented),
    .hypGroupTrap           (hypGroupTrap),
    .trapAllGroup1          (trapAllGroup1),
    .trapCommon             (trapCommon),
    .resp                   (route)
  );

  // ----------------------------------------------------------------
  // running priority: group priority at minimum binary point
  // ----------------------------------------------------------------
  logic [7:0] runPri;
  always_comb
  begin
    if (!activeValid)
      runPri = IDLE_PRIORITY;
    else
      runPri = {activePriority[7:1], 1'b0};
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    stateD = stateQ;
    stateD.respValid = 1'b0;
    stateD.respCode = RESP_NONE;
    stateD.respRdata = '0;
    stateD.physReq = 1'b0;
    stateD.physWrite = 1'b0;
    stateD.physSel = SEL_NONE;
    stateD.physWdata = '0;
    if (accValid)
    begin
      stateD.respValid = 1'b1;
      stateD.respCode = route;
      if (route == RESP_OK_PHYS)
      begin
        stateD.physReq = 1'b1;
        stateD.physWrite = accWrite;
        stateD.physSel = sel;
        stateD.physWdata = accWdata;
      end
      else if (route == RESP_OK_VIRT)
      begin
        case (sel)
          SEL_PMASK:
            if (accWrite)
              stateD.pmask = prioKeep(accWdata[7:0], PRIO_BITS);
            else
              stateD.respRdata = {24'h000000, stateQ.pmask};
          SEL_RUNPRI:
            stateD.respRdata = {24'h000000, runPri};
          SEL_GRP1EN:
            if (accWrite)
              stateD.grp1En = accWdata[0];
            else
              stateD.respRdata = {31'h00000000, stateQ.grp1En};
          default:
            stateD.respRdata = '0;
        endcase
      end
    end
    // interrupt filter uses the mask about to be held, so a write gates at once
    stateD.virtIrq = pendValid && stateD.grp1En
                     && (prioKeep(pendPriority, PRIO_BITS) < stateD.pmask);
  end

  // register the state
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stateQ <= '0;
      stateQ.pmask <= PMASK_RESET;
      stateQ.grp1En <= GRP1EN_RESET;
      stateQ.respCode <= RESP_NONE;
      stateQ.physSel <= SEL_NONE;
    end
    else
      stateQ <= stateD;
  end

  assign respValid = stateQ.respValid;
  assign respCode = stateQ.respCode;
  assign respRdata = (stateQ.physReq && !stateQ.physWrite) ? physRdata : stateQ.respRdata;
  assign physReq = stateQ.physReq;
  assign physWrite = stateQ.physWrite;
  assign physSel = stateQ.physSel;
  assign physWdata = stateQ.physWdata;
  assign virtIrq = stateQ.virtIrq;
  assign group1Enable = stateQ.grp1En;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_pmaskWrite;
    accValid && accWrite && sel == SEL_PMASK && route == RESP_OK_VIRT;
  endsequence

  property p_irqBelowMask;
    @(posedge clk) disable iff (!resetn)
      virtIrq |-> (prioKeep(pendPriority, PRIO_BITS) < stateQ.pmask) || $changed(pendPriority);
  endproperty
  a_irqBelowMask: assert property (p_irqBelowMask) else $error("irq above mask");

  property p_maskSelfSync;
    @(posedge clk) disable iff (!resetn)
      s_pmaskWrite ##1 (pendValid && $stable(pendPriority)
        && pendPriority >= stateQ.pmask) |-> !virtIrq;
  endproperty
  a_maskSelfSync: assert property (p_maskSelfSync) else $error("irq after mask write");

  property p_maskStored;
    @(posedge clk) disable iff (!resetn)
      s_pmaskWrite |=> stateQ.pmask == prioKeep($past(accWdata[7:0]), PRIO_BITS);
  endproperty
  a_maskStored: assert property (p_maskStored) else $error("mask not stored");

  property p_undef;
    @(posedge clk) disable iff (!resetn)
      sel != SEL_NONE && guestLevel && nonsecureSelect && !sysregIfaceEnable32
        |=> respValid && respCode == RESP_UNDEF;
  endproperty
  a_undef: assert property (p_undef) else $error("missing undefined");

  property p_physMask;
    @(posedge clk) disable iff (!resetn)
      accValid && route == RESP_OK_PHYS |=> physReq && physSel == $past(sel);
  endproperty
  a_physMask: assert property (p_physMask) else $error("no physical forward");

  property p_trapTc;
    @(posedge clk) disable iff (!resetn)
      sel == SEL_PMASK && guestLevel && nonsecureSelect && sysregIfaceEnable32
        && sysregIfaceEnable64 && trapCommon |=> respCode == RESP_TRAP_HYP;
  endproperty
  a_trapTc: assert property (p_trapTc) else $error("trap common missed");

  property p_trapAll1;
    @(posedge clk) disable iff (!resetn)
      sel == SEL_GRP1EN && guestLevel && nonsecureSelect && sysregIfaceEnable32
        && sysregIfaceEnable64 && trapAllGroup1 |=> respCode == RESP_TRAP_HYP;
  endproperty
  a_trapAll1: assert property (p_trapAll1) else $error("trap all group1 missed");

  property p_idle;
    @(posedge clk) disable iff (!resetn)
      sel == SEL_RUNPRI && route == RESP_OK_VIRT && !activeValid
        |=> respRdata == {24'h000000, IDLE_PRIORITY};
  endproperty
  a_idle: assert property (p_idle) else $error("idle priority wrong");

  property p_runPriLow;
    @(posedge clk) disable iff (!resetn)
      sel == SEL_RUNPRI && route == RESP_OK_VIRT && activeValid
        |=> respRdata[0] == 1'b0 && respRdata[DATA_W-1:8] == '0;
  endproperty
  a_runPriLow: assert property (p_runPriLow) else $error("running priority bits");

endmodule

// ---- phys_regs_model.sv ----
// Purpose: stands in for the physical registers beyond the block
// Assumes: one-cycle requests, read data due in the request cycle
// Notes:   between requests the data lines show the inverse of the last value
`timescale 1ns/1ps
module phys_regs_model
  import vcpu_prio_pkg::*;
#(
  parameter logic [31:0] RUN_PRI = 32'h00000060
)
(
  input  wire logic              clk,
  input  wire logic              physReq,
  input  wire logic              physWrite,
  input  wire sel_type           physSel,
  input  wire logic [DATA_W-1:0] physWdata,
  output logic      [DATA_W-1:0] physRdata
);
  logic [DATA_W-1:0] physMask_q = 32'h0;
  logic [DATA_W-1:0] lastShown_q = 32'h0;
  logic [DATA_W-1:0] value;
  // pick the selected register, scramble the lines when idle
  always_comb
  begin
    case (physSel)
      SEL_PMASK:  value = physMask_q;
      SEL_RUNPRI: value = RUN_PRI;
      default:    value = 32'h1;
    endcase
    physRdata = physReq ? value : ~lastShown_q;
  end
  // store mask writes, remember what was shown
  always @(posedge clk)
  begin
    if (physReq && physWrite && physSel == SEL_PMASK)
      physMask_q <= {24'h0, physWdata[7:0]};
    if (physReq)
      lastShown_q <= value;
  end
endmodule

// ---- tb.sv ----
// Purpose: self-checking bench for the virtual priority registers
// Assumes: eight implemented priority bits
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module tb import vcpu_prio_pkg::*;;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic              clk = 1'h0, resetn = 1'h0, accValid = 1'h0, accWrite = 1'h0;
  logic [3:0]        accCoproc = COPROC_SYS, accCrn = 4'h0, accCrm = 4'h0;
  logic [2:0]        accOpc1 = OPC1_GUEST, accOpc2 = 3'h0;
  logic [DATA_W-1:0] accWdata = 32'h0, respRdata, physWdata, physRdata, rData;
  logic              nonsecureSelect = 1'h1, guestLevel = 1'h1, hypImplemented = 1'h1;
  logic              fastIrqRouteOverride = 1'h1, normalIrqRouteOverride = 1'h1;
  logic              sysregIfaceEnable32 = 1'h1, sysregIfaceEnable64 = 1'h1;
  logic              hypGroupTrap = 1'h0, trapAllGroup1 = 1'h0, trapCommon = 1'h0;
  logic              activeValid = 1'h0, pendValid = 1'h0;
  logic [7:0]        activePriority = 8'h00, pendPriority = 8'h00;
  logic              respValid, physReq, physWrite, virtIrq, group1Enable;
  resp_type          respCode, rCode;
  sel_type           physSel;
  int                n_errors = 0, checks_done = 0;

  vcpu_prio_regs  u_dut (.*);
  phys_regs_model u_phys (.*);
  always #50 clk = ~clk;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chkData(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic chkCode(input resp_type got, input resp_type exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected code at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // one access: held until the taking edge, answer read just after it
  task automatic acc(input sel_type s, input logic w, input logic [31:0] d);
    case (s)
      SEL_PMASK:  {accCrn, accCrm, accOpc2} = {PMASK_CRN, PMASK_CRM, PMASK_OPC2};
      SEL_RUNPRI: {accCrn, accCrm, accOpc2} = {RUNPRI_CRN, RUNPRI_CRM, RUNPRI_OPC2};
      SEL_GRP1EN: {accCrn, accCrm, accOpc2} = {GRP1EN_CRN, GRP1EN_CRM, GRP1EN_OPC2};
      default:    {accCrn, accCrm, accOpc2} = 11'h111;
    endcase
    accWrite = w;
    accWdata = d;
    accValid = 1'h1;
    @(posedge clk);
    #1;
    rCode = respCode;
    rData = respRdata;
    chkData(32'(respValid), 32'h1);
    // release, then let one edge pass so the next call never re-raises in this step
    accValid = 1'h0;
    @(posedge clk);
    #1;
  endtask
  task automatic testReset();
    chkData(32'(group1Enable), 32'h0);
    acc(SEL_PMASK, 1'h0, 32'h0);
    chkCode(rCode, RESP_OK_VIRT);
    chkData(rData, 32'h0);
    $display("reset test done");
  endtask
  task automatic testFilter();
    pendValid = 1'h1;
    pendPriority = 8'h40;
    acc(SEL_GRP1EN, 1'h1, 32'h1);
    chkData(32'(group1Enable), 32'h1);
    acc(SEL_PMASK, 1'h1, 32'hFFFFFF41);
    chkData(32'(virtIrq), 32'h1);
    acc(SEL_PMASK, 1'h0, 32'h0);
    chkData(rData, 32'h41);
    acc(SEL_PMASK, 1'h1, 32'h40);
    chkData(32'(virtIrq), 32'h0);
    acc(SEL_PMASK, 1'h1, 32'hFF);
    acc(SEL_GRP1EN, 1'h1, 32'h0);
    chkData(32'(virtIrq), 32'h0);
    $display("filter test done");
  endtask
  task automatic testRunPri();
    acc(SEL_RUNPRI, 1'h0, 32'h0);
    chkData(rData, 32'hFF);
    activeValid = 1'h1;
    activePriority = 8'h43;
    acc(SEL_RUNPRI, 1'h0, 32'h0);
    chkData(rData, 32'h42);
    activePriority = 8'hFE;
    acc(SEL_RUNPRI, 1'h0, 32'h0);
    chkData(rData, 32'hFE);
    acc(SEL_RUNPRI, 1'h1, 32'h12);
    chkCode(rCode, RESP_NONE);
    acc(SEL_NONE, 1'h0, 32'h0);
    chkCode(rCode, RESP_NONE);
    $display("running priority test done");
  endtask
  task automatic testRoute();
    fastIrqRouteOverride = 1'h0;
    normalIrqRouteOverride = 1'h0;
    acc(SEL_PMASK, 1'h1, 32'h33);
    chkCode(rCode, RESP_OK_PHYS);
    acc(SEL_PMASK, 1'h0, 32'h0);
    chkData(rData, 32'h33);
    acc(SEL_RUNPRI, 1'h0, 32'h0);
    chkData(rData, 32'h60);
    acc(SEL_GRP1EN, 1'h0, 32'h0);
    chkCode(rCode, RESP_OK_PHYS);
    fastIrqRouteOverride = 1'h1;
    acc(SEL_PMASK, 1'h0, 32'h0);
    chkData(rData, 32'hFF);
    normalIrqRouteOverride = 1'h1;
    $display("routing test done");
  endtask
  task automatic testTraps();
    sysregIfaceEnable32 = 1'h0;
    acc(SEL_PMASK, 1'h1, 32'h10);
    chkCode(rCode, RESP_UNDEF);
    sysregIfaceEnable32 = 1'h1;
    sysregIfaceEnable64 = 1'h0;
    acc(SEL_RUNPRI, 1'h0, 32'h0);
    chkCode(rCode, RESP_TRAP_GST);
    sysregIfaceEnable64 = 1'h1;
    hypGroupTrap = 1'h1;
    acc(SEL_GRP1EN, 1'h0, 32'h0);
    chkCode(rCode, RESP_TRAP_HYP);
    hypGroupTrap = 1'h0;
    trapAllGroup1 = 1'h1;
    acc(SEL_GRP1EN, 1'h1, 32'h1);
    chkCode(rCode, RESP_TRAP_HYP);
    chkData(32'(group1Enable), 32'h0);
    trapAllGroup1 = 1'h0;
    trapCommon = 1'h1;
    acc(SEL_PMASK, 1'h1, 32'h10);
    chkCode(rCode, RESP_TRAP_HYP);
    nonsecureSelect = 1'h0;
    acc(SEL_PMASK, 1'h0, 32'h0);
    chkData(rData, 32'hFF);
    nonsecureSelect = 1'h1;
    trapCommon = 1'h0;
    $display("trap test done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    resetn = 1'h1;
    testReset();
    testFilter();
    testRunPri();
    testRoute();
    testTraps();
    finish_test();
  end
  // watchdog, far beyond the 23 accesses
  initial
  begin
    #200000;
    n_errors++;
    finish_test();
  end
endmodule
